// file: tb/ltc_far_bus.sv
// Far-side model of the shared logic bus: levels from the other primitives
// with the counters' comparator slots fed back, as every primitive sees them.
// Assumes the counters own bus bits 8 to 16 and nothing else drives them.
`timescale 1ns/1ps
`default_nettype none
module ltc_far_bus
    import ltc_pkg::*;
(
    // Levels from other primitives
    input wire logic [BUS_WIDTH-1:0] prim_lvl,
    // Comparator bits from the counters
    input wire logic [BUS_WIDTH-1:0] cmp_bits,
    // Bus as seen by all primitives
    output logic [BUS_WIDTH-1:0] bus
);
    // Comparator slots override, so a stray level can never mask a match
    assign bus = (prim_lvl & ~32'h0001_ff00) | (cmp_bits & 32'h0001_ff00);
endmodule // ltc_far_bus
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the tile counter group: counter 0 is driven from
// bus bits 1..4, the register port and the sequencer, against a model.
// Assumes the package and the far-side bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ltc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] seq_addr = 4'h0;
    logic [31:0] seq_wdata = 32'h0;
    // Strobes: reg wr, reg rd, seq wr, seq add, seq sub, seq rd
    logic [5:0] stb = 6'h00;
    logic [31:0] lvl = 32'h0;
    wire logic [31:0] bus;
    logic [31:0] bus_out, rdata, seq_rdata;
    logic [2:0][31:0] cnt;
    logic [31:0] m, mt1, newv, val, lf;
    logic pe;
    ltc_ctrl_type c;
    int num_errors = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;

    ltc_far_bus ltc_far_bus_inst (.prim_lvl(lvl), .cmp_bits(bus_out), .bus(bus));
    ltc_logic_tile_counters ltc_logic_tile_counters_inst (
        .CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(stb[5]), .REG_RD(stb[4]), .REG_RDATA(rdata), .LOGIC_BUS_IN(bus),
        .LOGIC_BUS_OUT(bus_out), .COUNT_VALUE(cnt), .SEQ_ADDR(seq_addr),
        .SEQ_WDATA(seq_wdata), .SEQ_WR(stb[3]), .SEQ_ADD(stb[2]), .SEQ_SUB(stb[1]),
        .SEQ_RD(stb[0]), .SEQ_RDATA(seq_rdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] ld(input logic [31:0] x);
        case (c.load_src)
            LOAD_SHIFT: return c.shift_left ? x << c.shift_amt : x >> c.shift_amt;
            LOAD_VALUE: return c.value_minus ? x - val : x + val;
            default: return newv;
        endcase
    endfunction

    task automatic chk(input logic ok, input string s);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("Error %0t: %s mismatch", $time, s);
        end
    endtask

    // Bus bits: [4] reset, [3] event, [2] direction, [1] enable
    task automatic step(input logic [31:0] v, input logic [5:0] s);
        lvl <= v;
        stb <= s;
        @(posedge clk);
        #1;
        if (v[4]) m = 32'h0;
        else if (pe && !v[3]) m = ld(m);
        else if (v[1]) m = v[2] ? m + 32'h1 : m - 32'h1;
        pe = v[3];
        chk(cnt[0] === m, "count");
        chk(bus_out[10:8] === {m == 32'h0, m == mt1, m == 32'h0}, "compare");
        chk({bus_out[31:11], bus_out[7:0]} === {15'h0, 6'h3f, 8'h0}, "bus bits");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        step(32'h0, 6'h20);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        step(32'h0, 6'h10);
        chk(rdata === e, "register read");
    endtask

    task automatic sq(input logic [3:0] a, input logic [31:0] d, input logic [5:0] s);
        seq_addr <= a;
        seq_wdata <= d;
        step(32'h0, s);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #100_000;
        num_errors++;
        $display("Error %0t: watchdog expired", $time);
        end_of_test;
    end

    initial begin
        m = 32'h0;
        mt1 = 32'h0;
        pe = 1'b0;
        lf = 32'h0001_6cd0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            step(32'h0, 6'h00);
            c = '0;
            c.sel_en = 5'd1;
            c.sel_dir = 5'd2;
            c.sel_evt = 5'd3;
            c.sel_rst = 5'd4;
            c.load_src = ltc_load_type'(2'(k % 3));
            c.shift_amt = 5'(k * 5);
            c.shift_left = k < 3;
            c.value_minus = k >= 3;
            val = lf;
            newv = ~lf;
            wr(ADDR_CTRL, c);
            wr(ADDR_VALUE, val);
            wr(ADDR_NEWVAL, newv);
            repeat (60) begin
                lf = lfsr(lf);
                step({27'h0, &lf[8:5], lf[3:1], 1'b0}, 6'h00);
            end
            $display("Test load config %0d done", k);
        end
        step(32'h0, 6'h00);
        rd(ADDR_CTRL, c);
        rd(ADDR_COUNT, m);
        wr(ADDR_COUNT, 32'h1234_5678);
        rd(8'h40, 32'h0);
        mt1 = m + 32'h2;
        sq(4'h1, mt1, 6'h08);
        step(32'h6, 6'h00);
        step(32'h6, 6'h00);
        sq(4'h1, 32'h0, 6'h01);
        chk(seq_rdata === mt1, "sequencer read");
        mt1 = mt1 + 32'h5;
        sq(4'h1, 32'h5, 6'h04);
        sq(4'h1, 32'h0, 6'h01);
        chk(seq_rdata === mt1, "sequencer add read");
        sq(4'h4, 32'h0, 6'h01);
        chk(seq_rdata === 32'h0, "sequencer read counter 1");
        m = m + 32'h10;
        sq(4'h0, 32'h10, 6'h04);
        m = m - 32'h3;
        sq(4'h0, 32'h3, 6'h02);
        wr(ADDR_IND_ADDR, 32'h0);
        wr(ADDR_IND_DATA, 32'hdead_beef);
        wr(ADDR_IND_TRIG, 32'h0);
        m = 32'hdead_beef;
        step(32'h0, 6'h00);
        step(32'h8, 6'h00);
        step(32'h12, 6'h00);
        chk(cnt[1] === 32'h0 && cnt[2] === 32'h0, "idle counters");
        rd(ADDR_STATUS, {22'h0, 6'h3f, m == 32'h0, m == mt1, m == 32'h0, 1'b0});
        rd(ADDR_IND_TRIG, 32'h0);
        $display("Test directed access done");
        end_of_test;
    end
endmodule // tb
`default_nettype wire

// file: verilog/ltc_bus_select.sv
// One-bit selector that picks a bit of the shared logic bus.
// Assumes the select code comes from a stable control register.
`timescale 1ns/1ps
`default_nettype none
module ltc_bus_select
    import ltc_pkg::*;
#(
    parameter int unsigned WIDTH = BUS_WIDTH
) (
    // Bus and selection
    input wire logic [WIDTH-1:0] bus,
    input wire logic [$clog2(WIDTH)-1:0] sel,
    // Selected bit
    output logic bit_out
);
    assign bit_out = bus[sel];
endmodule // ltc_bus_select
`default_nettype wire

// file: verilog/ltc_counter.sv
// One up/down counter with load selector, match registers and comparators.
// Assumes its four inputs are already picked from the logic bus, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ltc_counter
    import ltc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration
    input wire ltc_ctrl_type ctrl,
    input wire logic [COUNT_WIDTH-1:0] value,
    input wire logic [COUNT_WIDTH-1:0] newval,
    // Selected bus inputs
    input wire logic cnt_en,
    input wire logic cnt_dir,
    input wire logic cnt_evt,
    input wire logic cnt_rst,
    // Local register access
    input wire ltc_wr_type wr,
    // State
    output logic [COUNT_WIDTH-1:0] count,
    output logic [COUNT_WIDTH-1:0] match1,
    output logic [COUNT_WIDTH-1:0] match2,
    output ltc_cmp_type cmp
);
    logic evt_q;
    logic load_pulse;
    logic [COUNT_WIDTH-1:0] count_q, count_d, match1_q, match2_q, load_val, shifted;

    function automatic logic [COUNT_WIDTH-1:0] apply_op(input logic [COUNT_WIDTH-1:0] old,
                                                        input ltc_wr_type w);
        case (w.op)
            OP_ADD: apply_op = old + w.data;
            OP_SUB: apply_op = old - w.data;
            default: apply_op = w.data;
        endcase
    endfunction

    // Falling edge seen against the previous sample, so one load per edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_q <= 1'b0;
        end else begin
            evt_q <= cnt_evt;
        end
    end
    assign load_pulse = evt_q & ~cnt_evt;

    always_comb begin
        shifted = ctrl.shift_left ? (count_q << ctrl.shift_amt) : (count_q >> ctrl.shift_amt);
        case (ctrl.load_src)
            LOAD_SHIFT: load_val = shifted;
            LOAD_VALUE: load_val = ctrl.value_minus ? count_q - value : count_q + value;
            default: load_val = newval;
        endcase
    end

    always_comb begin
        if (cnt_rst) begin
            count_d = '0;
        end else if (load_pulse) begin
            count_d = load_val;
        end else if (wr.en && wr.target == TGT_COUNT) begin
            count_d = apply_op(count_q, wr);
        end else if (cnt_en) begin
            count_d = cnt_dir ? count_q + 32'h0000_0001 : count_q - 32'h0000_0001;
        end else begin
            count_d = count_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            match1_q <= '0;
            match2_q <= '0;
        end else if (wr.en) begin
            if (wr.target == TGT_MATCH1) begin
                match1_q <= apply_op(match1_q, wr);
            end
            if (wr.target == TGT_MATCH2) begin
                match2_q <= apply_op(match2_q, wr);
            end
        end
    end

    assign count = count_q;
    assign match1 = match1_q;
    assign match2 = match2_q;
    assign cmp.zero = (count_q == '0);
    assign cmp.match1 = (count_q == match1_q);
    assign cmp.match2 = (count_q == match2_q);
endmodule // ltc_counter
`default_nettype wire

// file: verilog/ltc_logic_tile_counters.sv
// Counter group of one logic tile: three counters, their bus input selectors,
// control registers, data exchange path and the sequencer's direct access port.
// Assumes all inputs are synchronous to CLK; the register master never waits.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Count steps by one, up when direction input high, down when low.
// - Count changes by stepping only while count enable is high.
// - Falling edge on event makes one-clock pulse that loads the selected value.
// - Load value is new value, shifted count, or count plus/minus value register.
// - Reset input clears the count to zero over every other input.
// - Each of the four counter inputs is picked from a bus bit by control.
// - Current count is presented as a 32-bit output.
// - Zero, match 1 and match 2 comparators are high while count equals their value.
// - Comparator bits sit at fixed positions of the shared logic bus.
// - Sequencer reads and writes count and both match registers directly.
// - The tile holds three independent counters.
// - Sequencer add and subtract can modify the counter registers.
module ltc_logic_tile_counters
    import ltc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Shared logic bus
    input wire logic [BUS_WIDTH-1:0] LOGIC_BUS_IN,
    output logic [BUS_WIDTH-1:0] LOGIC_BUS_OUT,
    // Counter values
    output logic [NUM_COUNTERS-1:0][COUNT_WIDTH-1:0] COUNT_VALUE,
    // Sequencer access
    input wire logic [3:0] SEQ_ADDR,
    input wire logic [31:0] SEQ_WDATA,
    input wire logic SEQ_WR,
    input wire logic SEQ_ADD,
    input wire logic SEQ_SUB,
    input wire logic SEQ_RD,
    output logic [31:0] SEQ_RDATA
);
    ltc_ctrl_type ctrl_q [NUM_COUNTERS];
    logic [31:0] value_q [NUM_COUNTERS];
    logic [31:0] newval_q [NUM_COUNTERS];
    logic [31:0] count_w [NUM_COUNTERS];
    logic [31:0] match1_w [NUM_COUNTERS];
    logic [31:0] match2_w [NUM_COUNTERS];
    ltc_cmp_type cmp_w [NUM_COUNTERS];
    ltc_wr_type wr_w [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] en_w, dir_w, evt_w, rst_w;
    logic [BUS_WIDTH-1:0] bus_w, cmp_bits;
    logic [3:0] ind_addr_q;
    logic [31:0] ind_data_q;
    ltc_ind_type ind_state_q;
    logic ind_go, seq_any;
    ltc_op_type seq_op;
    logic [31:0] rdata_q, rd_mux, seq_rdata_q, seq_mux;

    // Comparator bits overlay the incoming bus so every counter sees its
    // neighbours; they come from registered counts, so there is no loop.
    always_comb begin
        cmp_bits = '0;
        for (int n = 0; n < NUM_COUNTERS; n++) begin
            cmp_bits[CMP_BIT_BASE + CMP_BITS_PER*n] = cmp_w[n].zero;
            cmp_bits[CMP_BIT_BASE + CMP_BITS_PER*n + 1] = cmp_w[n].match1;
            cmp_bits[CMP_BIT_BASE + CMP_BITS_PER*n + 2] = cmp_w[n].match2;
        end
    end

    always_comb begin
        bus_w = LOGIC_BUS_IN;
        for (int n = 0; n < NUM_COUNTERS; n++) begin
            for (int b = 0; b < CMP_BITS_PER; b++) begin
                bus_w[CMP_BIT_BASE + CMP_BITS_PER*n + b] = cmp_bits[CMP_BIT_BASE + CMP_BITS_PER*n + b];
            end
        end
    end
    assign LOGIC_BUS_OUT = cmp_bits;

    // Sequencer operation; if several strobes coincide, write wins, then add
    assign seq_any = SEQ_WR | SEQ_ADD | SEQ_SUB;
    always_comb begin
        if (SEQ_WR) begin
            seq_op = OP_WRITE;
        end else if (SEQ_ADD) begin
            seq_op = OP_ADD;
        end else begin
            seq_op = OP_SUB;
        end
    end

    // Indirect write waits while the sequencer owns the local bus
    assign ind_go = (ind_state_q == IND_PEND) && !seq_any;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ind_state_q <= IND_IDLE;
        end else begin
            case (ind_state_q)
                IND_IDLE: begin
                    if (REG_WR && REG_ADDR == ADDR_IND_TRIG) begin
                        ind_state_q <= IND_PEND;
                    end
                end
                IND_PEND: begin
                    if (ind_go && !(REG_WR && REG_ADDR == ADDR_IND_TRIG)) begin
                        ind_state_q <= IND_IDLE;
                    end
                end
                default: ind_state_q <= IND_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ind_addr_q <= '0;
            ind_data_q <= WORD_RESET;
        end else if (REG_WR && REG_ADDR == ADDR_IND_ADDR) begin
            ind_addr_q <= REG_WDATA[3:0] & IND_ADDR_MASK;
        end else if (REG_WR && REG_ADDR == ADDR_IND_DATA) begin
            ind_data_q <= REG_WDATA;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_COUNTERS; g++) begin : g_cnt
            localparam logic [7:0] BASE = 8'(g * CNT_STRIDE);

            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    ctrl_q[g] <= ltc_ctrl_type'(CTRL_RESET);
                    value_q[g] <= WORD_RESET;
                    newval_q[g] <= WORD_RESET;
                end else if (REG_WR) begin
                    if (REG_ADDR == BASE + ADDR_CTRL) begin
                        ctrl_q[g] <= ltc_ctrl_type'(REG_WDATA & CTRL_MASK);
                    end
                    if (REG_ADDR == BASE + ADDR_VALUE) begin
                        value_q[g] <= REG_WDATA;
                    end
                    if (REG_ADDR == BASE + ADDR_NEWVAL) begin
                        newval_q[g] <= REG_WDATA;
                    end
                end
            end

            // Local write: sequencer first, a pending indirect write otherwise
            always_comb begin
                wr_w[g] = '0;
                if (seq_any && SEQ_ADDR[3:2] == 2'(g)) begin
                    wr_w[g].en = 1'b1;
                    wr_w[g].op = seq_op;
                    wr_w[g].target = SEQ_ADDR[1:0];
                    wr_w[g].data = SEQ_WDATA;
                end else if (ind_go && ind_addr_q[3:2] == 2'(g)) begin
                    wr_w[g].en = 1'b1;
                    wr_w[g].op = OP_WRITE;
                    wr_w[g].target = ind_addr_q[1:0];
                    wr_w[g].data = ind_data_q;
                end
            end

            ltc_bus_select #(.WIDTH(BUS_WIDTH)) u_sel_en (
                .bus(bus_w), .sel(ctrl_q[g].sel_en), .bit_out(en_w[g])
            );
            ltc_bus_select #(.WIDTH(BUS_WIDTH)) u_sel_dir (
                .bus(bus_w), .sel(ctrl_q[g].sel_dir), .bit_out(dir_w[g])
            );
            ltc_bus_select #(.WIDTH(BUS_WIDTH)) u_sel_evt (
                .bus(bus_w), .sel(ctrl_q[g].sel_evt), .bit_out(evt_w[g])
            );
            ltc_bus_select #(.WIDTH(BUS_WIDTH)) u_sel_rst (
                .bus(bus_w), .sel(ctrl_q[g].sel_rst), .bit_out(rst_w[g])
            );

            ltc_counter u_counter (
                .clk(CLK),
                .arst_n(ARST_N),
                .ctrl(ctrl_q[g]),
                .value(value_q[g]),
                .newval(newval_q[g]),
                .cnt_en(en_w[g]),
                .cnt_dir(dir_w[g]),
                .cnt_evt(evt_w[g]),
                .cnt_rst(rst_w[g]),
                .wr(wr_w[g]),
                .count(count_w[g]),
                .match1(match1_w[g]),
                .match2(match2_w[g]),
                .cmp(cmp_w[g])
            );
            assign COUNT_VALUE[g] = count_w[g];

            // Checking helpers: previous event sample and count-target write
            logic evt_prev_q;
            logic fall, wr_cnt;
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    evt_prev_q <= 1'b0;
                end else begin
                    evt_prev_q <= evt_w[g];
                end
            end
            assign fall = evt_prev_q & ~evt_w[g];
            assign wr_cnt = wr_w[g].en && wr_w[g].target == TGT_COUNT;

            sequence s_step;
                !rst_w[g] && !fall && !wr_cnt && en_w[g];
            endsequence
            sequence s_load_new;
                !rst_w[g] && fall && ctrl_q[g].load_src == LOAD_NEW;
            endsequence

            a_step_up: assert property (@(posedge CLK) disable iff (!ARST_N)
                s_step ##0 dir_w[g] |=> count_w[g] == $past(count_w[g]) + 32'h0000_0001)
                else $error("count did not step up by one");
            a_step_down: assert property (@(posedge CLK) disable iff (!ARST_N)
                s_step ##0 !dir_w[g] |=> count_w[g] == $past(count_w[g]) - 32'h0000_0001)
                else $error("count did not step down by one");
            a_hold_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
                !rst_w[g] && !fall && !wr_cnt && !en_w[g] |=> $stable(count_w[g]))
                else $error("count moved while disabled");
            a_load_wins: assert property (@(posedge CLK) disable iff (!ARST_N)
                s_load_new |=> count_w[g] == $past(newval_q[g]))
                else $error("falling event did not load new value");
            a_load_offset: assert property (@(posedge CLK) disable iff (!ARST_N)
                !rst_w[g] && fall && ctrl_q[g].load_src == LOAD_VALUE && !ctrl_q[g].value_minus
                |=> count_w[g] == $past(count_w[g]) + $past(value_q[g]))
                else $error("offset load wrong");
            a_reset_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
                rst_w[g] |=> count_w[g] == 32'h0000_0000)
                else $error("reset input did not clear count");
            a_zero_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
                LOGIC_BUS_OUT[CMP_BIT_BASE + CMP_BITS_PER*g] == (count_w[g] == 32'h0000_0000))
                else $error("zero bit wrong on bus");
            a_match_bits: assert property (@(posedge CLK) disable iff (!ARST_N)
                LOGIC_BUS_OUT[CMP_BIT_BASE + CMP_BITS_PER*g + 2] == (count_w[g] == match2_w[g]))
                else $error("match 2 bit wrong on bus");
            a_seq_add: assert property (@(posedge CLK) disable iff (!ARST_N)
                SEQ_ADD && !SEQ_WR && SEQ_ADDR == {2'(g), TGT_MATCH1}
                |=> match1_w[g] == $past(match1_w[g]) + $past(SEQ_WDATA))
                else $error("sequencer add on match 1 wrong");
            a_match1_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
                LOGIC_BUS_OUT[CMP_BIT_BASE + CMP_BITS_PER*g + 1] == (count_w[g] == match1_w[g]))
                else $error("match 1 bit wrong on bus");
            a_load_shift: assert property (@(posedge CLK) disable iff (!ARST_N)
                !rst_w[g] && fall && ctrl_q[g].load_src == LOAD_SHIFT && ctrl_q[g].shift_left
                |=> count_w[g] == ($past(count_w[g]) << $past(ctrl_q[g].shift_amt)))
                else $error("shifted load wrong");
            a_local_write: assert property (@(posedge CLK) disable iff (!ARST_N)
                !rst_w[g] && !fall && wr_cnt && wr_w[g].op == OP_WRITE
                |=> count_w[g] == $past(wr_w[g].data))
                else $error("local write to count lost");
            a_match_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
                !wr_w[g].en |=> $stable(match1_w[g]) && $stable(match2_w[g]))
                else $error("match register moved without a write");
        end
    endgenerate

    // Register read: one cycle later, zero for unmapped and write-only words.
    // The data exchange words do not reflect the counters themselves.
    always_comb begin
        rd_mux = '0;
        for (int n = 0; n < NUM_COUNTERS; n++) begin
            if (REG_ADDR == 8'(n * CNT_STRIDE) + ADDR_CTRL) begin
                rd_mux = 32'(ctrl_q[n]);
            end
            if (REG_ADDR == 8'(n * CNT_STRIDE) + ADDR_VALUE) begin
                rd_mux = value_q[n];
            end
            if (REG_ADDR == 8'(n * CNT_STRIDE) + ADDR_NEWVAL) begin
                rd_mux = newval_q[n];
            end
            if (REG_ADDR == 8'(n * CNT_STRIDE) + ADDR_COUNT) begin
                rd_mux = count_w[n];
            end
        end
        if (REG_ADDR == ADDR_IND_ADDR) begin
            rd_mux = {28'h0000000, ind_addr_q};
        end
        if (REG_ADDR == ADDR_IND_DATA) begin
            rd_mux = ind_data_q;
        end
        if (REG_ADDR == ADDR_STATUS) begin
            rd_mux = {22'h000000, cmp_bits[CMP_BIT_BASE +: 9], ind_state_q == IND_PEND};
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= REG_RD ? rd_mux : 32'h0000_0000;
        end
    end
    assign REG_RDATA = rdata_q;

    // Sequencer direct read of count and match registers
    always_comb begin
        seq_mux = '0;
        for (int n = 0; n < NUM_COUNTERS; n++) begin
            if (SEQ_ADDR[3:2] == 2'(n)) begin
                case (SEQ_ADDR[1:0])
                    TGT_COUNT: seq_mux = count_w[n];
                    TGT_MATCH1: seq_mux = match1_w[n];
                    TGT_MATCH2: seq_mux = match2_w[n];
                    default: seq_mux = '0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            seq_rdata_q <= '0;
        end else begin
            seq_rdata_q <= SEQ_RD ? seq_mux : 32'h0000_0000;
        end
    end
    assign SEQ_RDATA = seq_rdata_q;

    a_ind_issue: assert property (@(posedge CLK) disable iff (!ARST_N)
        REG_WR && REG_ADDR == ADDR_IND_TRIG && !SEQ_WR && !SEQ_ADD && !SEQ_SUB
        ##1 !SEQ_WR && !SEQ_ADD && !SEQ_SUB |-> ind_go)
        else $error("indirect write not issued after trigger");
    a_seq_read: assert property (@(posedge CLK) disable iff (!ARST_N)
        SEQ_RD && SEQ_ADDR[1:0] == TGT_COUNT && SEQ_ADDR[3:2] == 2'h1
        |=> SEQ_RDATA == $past(count_w[1]))
        else $error("sequencer read of count wrong");
    a_seq_rdata_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
        !SEQ_RD |=> SEQ_RDATA == 32'h0)
        else $error("sequencer read data not cleared");

endmodule // ltc_logic_tile_counters
`default_nettype wire

// file: verilog/ltc_pkg.sv
// Shared constants and types for the logic tile counter group.
// Assumes a 32-bit shared logic bus and a byte-addressed register port.
package ltc_pkg;

    localparam int unsigned NUM_COUNTERS = 3;
    localparam int unsigned BUS_WIDTH = 32;
    localparam int unsigned COUNT_WIDTH = 32;
    localparam int unsigned SEL_WIDTH = 5;
    localparam int unsigned ADDR_WIDTH = 8;

    // Per-counter register block, repeated every CNT_STRIDE bytes
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VALUE = 8'h04;
    localparam logic [7:0] ADDR_NEWVAL = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] CNT_STRIDE = 8'h10;
    // Data exchange and status registers
    localparam logic [7:0] ADDR_IND_ADDR = 8'h30;
    localparam logic [7:0] ADDR_IND_DATA = 8'h34;
    localparam logic [7:0] ADDR_IND_TRIG = 8'h38;
    localparam logic [7:0] ADDR_STATUS = 8'h3c;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h1fff_ffff;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [3:0] IND_ADDR_MASK = 4'hf;

    // Comparator bits of counter n sit at CMP_BIT_BASE + 3n (zero, match 1, match 2)
    localparam int unsigned CMP_BIT_BASE = 8;
    localparam int unsigned CMP_BITS_PER = 3;

    // Local register address: [3:2] counter, [1:0] target
    localparam logic [1:0] TGT_COUNT = 2'h0;
    localparam logic [1:0] TGT_MATCH1 = 2'h1;
    localparam logic [1:0] TGT_MATCH2 = 2'h2;

    typedef enum logic [1:0] {LOAD_NEW = 2'h0, LOAD_SHIFT = 2'h1, LOAD_VALUE = 2'h2} ltc_load_type;
    typedef enum logic [1:0] {OP_WRITE = 2'h0, OP_ADD = 2'h1, OP_SUB = 2'h2} ltc_op_type;
    typedef enum logic [1:0] {IND_IDLE = 2'b01, IND_PEND = 2'b10} ltc_ind_type;

    typedef struct packed {
        logic [2:0] rsvd;
        logic value_minus;
        logic [4:0] shift_amt;
        logic shift_left;
        ltc_load_type load_src;
        logic [4:0] sel_rst;
        logic [4:0] sel_evt;
        logic [4:0] sel_dir;
        logic [4:0] sel_en;
    } ltc_ctrl_type;

    typedef struct packed {
        logic en;
        ltc_op_type op;
        logic [1:0] target;
        logic [31:0] data;
    } ltc_wr_type;

    typedef struct packed {
        logic zero;
        logic match1;
        logic match2;
    } ltc_cmp_type;

endpackage
